// ---- rtl/tpc_config_regs.v ----
/*
 * apb register bank for the converter loop and system clock divider,
 * with the reference mux, pre-divider and dac summation it steers.
 * assumes apb master in the mclk domain; clock pins come from outside.
 */
//
// Contract
// - pre-divider codes bypass,2,4,8,16; reset divide-by-2
// - pre-divider follows the selected reference source
// - modulator enable with order first or second picks multi-modulus, else integer
// - order field integer, first, second; reset first
// - feedback integer 8 bits, reset 0x23
// - feedback fraction 16 bits, reset 0x2800
// - dac input is baseline plus dynamic clipped to 16
// - system clock is vco over four over integer
`timescale 1ns/1ps
`include "tpc_defines.vh"

module tpc_config_regs (
    // clock and reset
    input  wire        mclk,
    input  wire        nrst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata_ff,
    output reg         pready_ff,
    output reg         pslverr_ff,
    // reference sources (asynchronous pins)
    input  wire        ref_select,
    input  wire        ref_input_clk,
    input  wire        ref_pin_clk,
    // modulator dynamic value
    input  wire [4:0]  dac_dynamic,
    // loop controls
    output reg  [2:0]  ref_predivider_ff,
    output reg         ref_divided_tick_ff,
    output reg         feedback_modulator_enable_ff,
    output reg  [1:0]  feedback_modulator_order_ff,
    output reg         multi_modulus_divider_ff,
    output reg  [7:0]  feedback_integer_value_ff,
    output reg  [15:0] feedback_fraction_value_ff,
    output reg  [4:0]  dac_baseline_ff,
    output reg  [5:0]  dac_input_ff,
    output reg  [4:0]  sys_div_integer_ff,
    output reg  [6:0]  sys_total_divide_ff
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    reg  [2:0]  prediv_ff;
    reg         mod_en_ff;
    reg  [1:0]  mod_order_ff;
    reg  [7:0]  fb_int_ff;
    reg  [15:0] fb_frac_ff;
    reg  [4:0]  dac_base_ff;
    reg  [4:0]  sys_div_ff;

    // first access edge raises pready; a write lands only on the pready edge
    wire        acc_en = psel & penable & ~pready_ff;
    wire        wr_en  = psel & penable & pwrite & pready_ff;
    wire        rd_en  = acc_en & ~pwrite;
    reg         addr_hit;
    reg  [31:0] rd_word;

    // ------------------------------------------------------------
    // address decode and read mux
    // ------------------------------------------------------------
    always @* begin
        addr_hit = 1'b1;
        rd_word  = 32'h0000_0000;
        case (paddr)
            `TPC_OFS_REF_PREDIV: rd_word = {29'h0, prediv_ff};
            `TPC_OFS_MOD_CTRL:   rd_word = {24'h0, mod_en_ff, 5'h00, mod_order_ff};
            `TPC_OFS_FB_INT:     rd_word = {24'h0, fb_int_ff};
            `TPC_OFS_FB_FRAC:    rd_word = {16'h0, fb_frac_ff};
            `TPC_OFS_DAC_BASE:   rd_word = {27'h0, dac_base_ff};
            `TPC_OFS_SYS_DIV:    rd_word = {27'h0, sys_div_ff};
            default:             addr_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // register writes; only declared field bits are stored
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (!nrst) begin
            prediv_ff    <= `TPC_RST_PREDIV;
            mod_en_ff    <= `TPC_RST_MOD_EN;
            mod_order_ff <= `TPC_RST_MOD_ORDER;
            fb_int_ff    <= `TPC_RST_FB_INT;
            fb_frac_ff   <= `TPC_RST_FB_FRAC;
            dac_base_ff  <= `TPC_RST_DAC_BASE;
            sys_div_ff   <= `TPC_RST_SYS_DIV;
        end else if (wr_en && addr_hit) begin
            case (paddr)
                `TPC_OFS_REF_PREDIV: begin
                    if (pstrb[0]) begin
                        prediv_ff <= pwdata[2:0];
                    end
                end
                `TPC_OFS_MOD_CTRL: begin
                    if (pstrb[0]) begin
                        mod_en_ff    <= pwdata[`TPC_MOD_EN_BIT];
                        mod_order_ff <= pwdata[`TPC_MOD_ORDER_HI:`TPC_MOD_ORDER_LO];
                    end
                end
                `TPC_OFS_FB_INT: begin
                    if (pstrb[0]) begin
                        fb_int_ff <= pwdata[7:0];
                    end
                end
                `TPC_OFS_FB_FRAC: begin
                    if (pstrb[0]) begin
                        fb_frac_ff[7:0] <= pwdata[7:0];
                    end
                    if (pstrb[1]) begin
                        fb_frac_ff[15:8] <= pwdata[15:8];
                    end
                end
                `TPC_OFS_DAC_BASE: begin
                    // values above 16 are stored as written; software must avoid them
                    if (pstrb[0]) begin
                        dac_base_ff <= pwdata[4:0];
                    end
                end
                `TPC_OFS_SYS_DIV: begin
                    if (pstrb[0]) begin
                        sys_div_ff <= pwdata[4:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // apb answer: one wait state, registered
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (!nrst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= acc_en;
            pslverr_ff <= acc_en & ~addr_hit;
            if (rd_en && addr_hit) begin
                prdata_ff <= rd_word;
            end else begin
                prdata_ff <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // reference pin synchronisers and mux
    // ------------------------------------------------------------
    reg  [1:0] sel_sync_ff;
    reg  [1:0] in_sync_ff;
    reg  [1:0] pin_sync_ff;
    reg        ref_prev_ff;
    reg        ref_cur;
    wire       ref_tick;

    always @(posedge mclk) begin
        if (!nrst) begin
            sel_sync_ff <= 2'b00;
            in_sync_ff  <= 2'b00;
            pin_sync_ff <= 2'b00;
            ref_prev_ff <= 1'b0;
        end else begin
            sel_sync_ff <= {sel_sync_ff[0], ref_select};
            in_sync_ff  <= {in_sync_ff[0], ref_input_clk};
            pin_sync_ff <= {pin_sync_ff[0], ref_pin_clk};
            ref_prev_ff <= ref_cur;
        end
    end

    always @* begin
        // reference must run well below mclk/2 for edges to be seen
        ref_cur = sel_sync_ff[1] ? pin_sync_ff[1] : in_sync_ff[1];
    end

    assign ref_tick = ref_cur & ~ref_prev_ff;

    wire div_tick;

    tpc_ref_divider u_ref_div (
        .mclk        (mclk),
        .nrst        (nrst),
        .ratio_sel   (prediv_ff),
        .ref_tick    (ref_tick),
        .div_tick_ff (div_tick)
    );

    wire [5:0] dac_sum;

    tpc_dac_sum u_dac_sum (
        .mclk      (mclk),
        .nrst      (nrst),
        .baseline  (dac_base_ff),
        .dynamic   (dac_dynamic),
        .dac_in_ff (dac_sum)
    );

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    reg nxt_multi_mod;

    always @* begin
        // reserved order code treated as integer, i.e. no modulation
        nxt_multi_mod = mod_en_ff && (mod_order_ff != 2'h0)
                  && (mod_order_ff != `TPC_ORDER_RSVD);
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            ref_predivider_ff            <= `TPC_RST_PREDIV;
            ref_divided_tick_ff          <= 1'b0;
            feedback_modulator_enable_ff <= `TPC_RST_MOD_EN;
            feedback_modulator_order_ff  <= `TPC_RST_MOD_ORDER;
            multi_modulus_divider_ff     <= 1'b1;
            feedback_integer_value_ff    <= `TPC_RST_FB_INT;
            feedback_fraction_value_ff   <= `TPC_RST_FB_FRAC;
            dac_baseline_ff              <= `TPC_RST_DAC_BASE;
            dac_input_ff                 <= 6'h00;
            sys_div_integer_ff           <= `TPC_RST_SYS_DIV;
            sys_total_divide_ff          <= 7'h30;
        end else begin
            ref_predivider_ff            <= prediv_ff;
            ref_divided_tick_ff          <= div_tick;
            feedback_modulator_enable_ff <= mod_en_ff;
            feedback_modulator_order_ff  <= mod_order_ff;
            multi_modulus_divider_ff     <= nxt_multi_mod;
            feedback_integer_value_ff    <= fb_int_ff;
            feedback_fraction_value_ff   <= fb_frac_ff;
            dac_baseline_ff              <= dac_base_ff;
            dac_input_ff                 <= dac_sum;
            sys_div_integer_ff           <= sys_div_ff;
            // total vco-to-system ratio, 4 times the integer
            sys_total_divide_ff          <= {sys_div_ff, 2'b00};
        end
    end

endmodule

// ---- rtl/tpc_dac_sum.v ----
/*
 * adds the dynamic modulator value to the baseline dac setting.
 * assumes both inputs are mclk-domain values.
 */
`timescale 1ns/1ps
`include "tpc_defines.vh"

module tpc_dac_sum (
    // clock and reset
    input  wire       mclk,
    input  wire       nrst,
    // operands
    input  wire [4:0] baseline,
    input  wire [4:0] dynamic,
    // result
    output reg  [5:0] dac_in_ff
);

    reg [4:0] dyn_clip;

    always @* begin
        // dynamic span is 0..16; clip anything larger
        dyn_clip = (dynamic > `TPC_DAC_DYN_MAX) ? `TPC_DAC_DYN_MAX : dynamic;
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            dac_in_ff <= 6'h00;
        end else begin
            dac_in_ff <= {1'b0, baseline} + {1'b0, dyn_clip};
        end
    end

endmodule

// ---- rtl/tpc_defines.vh ----
/*
 * register offsets, field positions and reset values of the loop
 * configuration bank. assumes inclusion by bare name, no other state.
 */
`ifndef TPC_DEFINES_VH
`define TPC_DEFINES_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define TPC_OFS_REF_PREDIV   12'h000
`define TPC_OFS_MOD_CTRL     12'h004
`define TPC_OFS_FB_INT       12'h008
`define TPC_OFS_FB_FRAC      12'h00C
`define TPC_OFS_DAC_BASE     12'h010
`define TPC_OFS_SYS_DIV      12'h014

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TPC_MOD_EN_BIT       7
`define TPC_MOD_ORDER_HI     1
`define TPC_MOD_ORDER_LO     0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TPC_RST_PREDIV       3'h1
`define TPC_RST_MOD_EN       1'h1
`define TPC_RST_MOD_ORDER    2'h1
`define TPC_RST_FB_INT       8'h23
`define TPC_RST_FB_FRAC      16'h2800
`define TPC_RST_DAC_BASE     5'h04
`define TPC_RST_SYS_DIV      5'h0C

// ------------------------------------------------------------
// encodings and limits
// ------------------------------------------------------------
`define TPC_PREDIV_BYPASS    3'h0
`define TPC_PREDIV_MAX       3'h4
`define TPC_ORDER_RSVD       2'h3
`define TPC_DAC_DYN_MAX      5'h10
`define TPC_VCO_PREDIV       4

`endif

// ---- rtl/tpc_ref_divider.v ----
/*
 * reference pre-divider counter: divides a clock-enable-style reference
 * tick stream by 1,2,4,8 or 16. assumes ref_tick already synchronous to mclk.
 */
`timescale 1ns/1ps
`include "tpc_defines.vh"

module tpc_ref_divider (
    // clock and reset
    input  wire       mclk,
    input  wire       nrst,
    // control
    input  wire [2:0] ratio_sel,
    input  wire       ref_tick,
    // output
    output reg        div_tick_ff
);

    reg  [3:0] cnt_ff;
    reg  [3:0] nxt_cnt;
    reg  [3:0] top;
    reg        nxt_div_tick;

    always @* begin
        // codes 4 and above all give divide-by-16, keeping the counter bounded
        case (ratio_sel)
            3'h0:    top = 4'h0;
            3'h1:    top = 4'h1;
            3'h2:    top = 4'h3;
            3'h3:    top = 4'h7;
            default: top = 4'hF;
        endcase
        nxt_cnt      = cnt_ff;
        nxt_div_tick = 1'b0;
        if (ref_tick) begin
            if (cnt_ff >= top) begin
                nxt_cnt      = 4'h0;
                nxt_div_tick = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 4'h1;
            end
        end
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            cnt_ff      <= 4'h0;
            div_tick_ff <= 1'b0;
        end else begin
            cnt_ff      <= nxt_cnt;
            div_tick_ff <= nxt_div_tick;
        end
    end

endmodule

// ---- tb/tdc_pll_and_sysclk_divider_config_test.sv ----
/* self-checking bench for tpc_config_regs over apb.
   assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module tdc_pll_and_sysclk_divider_config_test;
    reg         mclk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    reg         ref_select = 1'h0, ref_input_clk = 1'h0, ref_pin_clk = 1'h0;
    reg  [11:0] paddr = 12'h0;
    reg  [31:0] pwdata = 32'h0, rv;
    reg  [3:0]  pstrb = 4'h0;
    reg  [4:0]  dac_dynamic = 5'h0;
    reg         re;
    wire [31:0] prdata_ff;
    wire        pready_ff, pslverr_ff, tick, en, multi;
    wire [2:0]  prediv;
    wire [1:0]  order;
    wire [7:0]  fint;
    wire [15:0] frac;
    wire [4:0]  base, sdiv;
    wire [5:0]  dac;
    wire [6:0]  total;
    integer     n_errors = 0, num_checks = 0, j;
    // reset values, writes with reserved bits set but fields kept in their
    // software ranges except the order field, written as reserved code 3,
    // and the readback; register i at byte address 4*i
    localparam [191:0] RSTV = {32'hC, 32'h4, 32'h2800, 32'h23, 32'h81, 32'h1};
    localparam [191:0] WRV  = {32'hFFFFFFEF, 32'hFFFFFFF0, 32'hFFFFFFFF,
                               32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFC};
    localparam [191:0] MSKV = {32'hF, 32'h10, 32'hFFFF, 32'hFF, 32'h83, 32'h4};

    tpc_config_regs u_tpc_config_regs (
        .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_ff(prdata_ff),
        .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .ref_select(ref_select),
        .ref_input_clk(ref_input_clk), .ref_pin_clk(ref_pin_clk),
        .dac_dynamic(dac_dynamic), .ref_predivider_ff(prediv),
        .ref_divided_tick_ff(tick), .feedback_modulator_enable_ff(en),
        .feedback_modulator_order_ff(order), .multi_modulus_divider_ff(multi),
        .feedback_integer_value_ff(fint), .feedback_fraction_value_ff(frac),
        .dac_baseline_ff(base), .dac_input_ff(dac), .sys_div_integer_ff(sdiv),
        .sys_total_divide_ff(total)
    );

    initial begin
        forever #10 mclk = ~mclk;
    end

    task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("MISMATCH %0s exp %h got %h", nm, e, g);
            end
        end
    endtask

    // one apb transfer; waits on pready, bounded only by the watchdog
    task apb(input [11:0] a, input w, input [31:0] d);
        begin
            @(posedge mclk);
            psel <= 1'h1;
            penable <= 1'h0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            pstrb <= 4'hF;
            @(posedge mclk);
            penable <= 1'h1;
            @(posedge mclk);
            while (pready_ff !== 1'h1) @(posedge mclk);
            rv = prdata_ff;
            re = pslverr_ff;
            psel <= 1'h0;
            penable <= 1'h0;
            repeat (2) @(posedge mclk);
        end
    endtask

    task t_regs;
        integer i;
        begin
            chk("dac0", 32'h4, dac);
            for (i = 0; i < 6; i = i + 1) begin
                apb(i * 4, 1'h0, 32'h0);
                chk("reset", RSTV[i*32+:32], rv);
                apb(i * 4, 1'h1, WRV[i*32+:32]);
                apb(i * 4, 1'h0, 32'h0);
                chk("mask", MSKV[i*32+:32], rv);
            end
            chk("frac", 32'hFFFF, frac);
            chk("int", 32'hFF, fint);
            $display("t_regs done");
        end
    endtask

    task t_err;
        begin
            apb(12'h018, 1'h1, 32'hFF);
            chk("werr", 32'h1, re);
            apb(12'h002, 1'h0, 32'h0);
            chk("rerr", 32'h1, re);
            chk("rzero", 32'h0, rv);
            $display("t_err done");
        end
    endtask

    task t_mod;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                apb(12'h004, 1'h1, {24'h0, i[2], 5'h0, i[1:0]});
                chk("en", i[2], en);
                chk("order", i[1:0], order);
                chk("multi", i[2] && (i[1:0] == 1 || i[1:0] == 2), multi);
            end
            $display("t_mod done");
        end
    endtask

    task t_dac_sys;
        integer i;
        reg [4:0] b, d;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                b = 5'h10 - i * 3;
                d = i * 4;
                dac_dynamic <= d;
                apb(12'h010, 1'h1, b);
                repeat (4) @(posedge mclk);
                chk("dac", b + (d > 16 ? 16 : d), dac);
                apb(12'h014, 1'h1, 10 + i);
                chk("sdiv", 10 + i, sdiv);
                chk("total", 4 * (10 + i), total);
            end
            $display("t_dac_sys done");
        end
    endtask

    // 32 rising edges of period six cycles, on the chosen pins
    task t_ref(input s, input [2:0] c, input ti, input tp, input [31:0] e);
        integer i, n;
        begin
            apb(12'h000, 1'h1, c);
            chk("prediv", c, prediv);
            ref_select <= s;
            n = 0;
            for (i = 0; i < 240; i = i + 1) begin
                @(posedge mclk);
                n = n + tick;
                if (i >= 24 && i < 219) begin
                    ref_input_clk <= ti & ((i / 3) % 2);
                    ref_pin_clk <= tp & ((i / 3) % 2);
                end
            end
            chk("ticks", e, n);
            $display("t_ref done");
        end
    endtask

    task test_done;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_errors);
            if (n_errors == 0 && num_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    initial begin
        #400000;
        n_errors = n_errors + 1;
        test_done;
    end

    initial begin
        repeat (3) @(posedge mclk);
        nrst <= 1'h1;
        repeat (3) @(posedge mclk);
        t_regs;
        t_err;
        t_mod;
        t_dac_sys;
        for (j = 0; j < 6; j = j + 1)
            t_ref(j % 2, j, j % 2 == 0, j % 2, 32 >> (j > 4 ? 4 : j));
        t_ref(1'h1, 3'h0, 1'h1, 1'h0, 32'h0);
        test_done;
    end
endmodule

// ---- tb/tpc_config_regs_chk.sv ----
/* port checker for tpc_config_regs.
   assumes the bind below and one mclk domain. */
`timescale 1ns/1ps
module tpc_chk (
    // watched ports
    input wire        mclk,
    input wire        nrst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire [31:0] prdata_ff,
    input wire        pready_ff,
    input wire        pslverr_ff,
    input wire [4:0]  dac_dynamic,
    input wire        feedback_modulator_enable_ff,
    input wire [1:0]  feedback_modulator_order_ff,
    input wire        multi_modulus_divider_ff,
    input wire [7:0]  feedback_integer_value_ff,
    input wire [4:0]  dac_baseline_ff,
    input wire [5:0]  dac_input_ff,
    input wire [4:0]  sys_div_integer_ff,
    input wire [6:0]  sys_total_divide_ff
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire       acc  = psel && penable && !pready_ff;
    wire [7:0] wd_lo = pwdata[7:0];
    // dynamic part above 16 is clipped
    wire [4:0] clip = (dac_dynamic > 5'h10) ? 5'h10 : dac_dynamic;
    property p_wait; acc |=> pready_ff; endproperty
    a_wait: assert property (p_wait) else $error("no answer after one wait");
    property p_pulse; pready_ff |=> !pready_ff; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_err; pslverr_ff |-> pready_ff; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_rdz; !pready_ff |-> prdata_ff == 32'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("read data outside answer");
    property p_multi_mod;
        multi_modulus_divider_ff == (feedback_modulator_enable_ff &&
            (feedback_modulator_order_ff == 2'h1 || feedback_modulator_order_ff == 2'h2));
    endproperty
    a_multi_mod: assert property (p_multi_mod) else $error("divider mode wrong");
    property p_total; sys_total_divide_ff == {sys_div_integer_ff, 2'h0}; endproperty
    a_total: assert property (p_total) else $error("total divide wrong");
    property p_dac;
        ($stable(dac_dynamic) && $stable(dac_baseline_ff)) [*4]
            |-> dac_input_ff == {1'h0, dac_baseline_ff} + {1'h0, clip};
    endproperty
    a_dac: assert property (p_dac) else $error("dac sum wrong");
    property p_int;
        acc && pwrite && paddr == 12'h008 && pstrb[0]
            |-> ##3 feedback_integer_value_ff == $past(wd_lo, 3);
    endproperty
    a_int: assert property (p_int) else $error("integer write lost");
endmodule

bind tpc_config_regs tpc_chk u_tpc_chk (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_ff(prdata_ff),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .dac_dynamic(dac_dynamic),
    .feedback_modulator_enable_ff(feedback_modulator_enable_ff),
    .feedback_modulator_order_ff(feedback_modulator_order_ff),
    .multi_modulus_divider_ff(multi_modulus_divider_ff),
    .feedback_integer_value_ff(feedback_integer_value_ff),
    .dac_baseline_ff(dac_baseline_ff), .dac_input_ff(dac_input_ff),
    .sys_div_integer_ff(sys_div_integer_ff), .sys_total_divide_ff(sys_total_divide_ff)
);
